/* File: shared/drs_pkg.sv */
// Purpose: Shared constants and carriers for dual path reference select
// Assumes: One system clock, monitors on the same clock
// Notes:   Priority 1 is the most preferred value, 0 excludes an input
package drs_pkg;
	// Input and reference counts
	localparam int N_IN       = 18;
	localparam int N_REF      = 14;
	localparam int N_MAIN_OUT = 11;
	localparam int N_AUX_OUT  = 9;
	localparam int N_PIN      = 4;
	localparam int PRIO_W     = 4;
	localparam int FREQ_W     = 16;
	localparam int MEAS_W     = 16;
	// Reset value of the per-port enables: all disabled
	localparam logic [N_IN-1:0] PORT_EN_RST = 18'h00000;
	// Main loop bandwidth: ten steps, 0.1 Hz to 70 Hz
	localparam int BW_MAIN_MIN_MHZ = 100;
	localparam int BW_MAIN_MAX_MHZ = 70000;
	localparam logic [3:0] BW_MAIN_STEPS = 4'hA;
	localparam logic [3:0] BW_MAIN_RST   = 4'h0;
	// Auxiliary loop bandwidth codes
	localparam logic [1:0] BW_AUX_18HZ = 2'h0;
	localparam logic [1:0] BW_AUX_35HZ = 2'h1;
	localparam logic [1:0] BW_AUX_70HZ = 2'h2;
	// Fixed loop rates in kHz
	localparam logic [16:0] MAIN_DDS_KHZ = 17'h12FC0; // 77760 kHz
	localparam logic [16:0] FOLLOW_KHZ   = 17'h00008; // 8 kHz
	// Accepted input range in kHz, divider reach
	localparam int IN_MIN_KHZ   = 2;
	localparam int IN_MAX_KHZ   = 155520;
	localparam int DIVN_MAX_KHZ = 100000;
	localparam logic [13:0] DIVN_N_MIN = 14'h0001; // ratio 2
	localparam logic [13:0] DIVN_N_MAX = 14'h30D3; // ratio 12500
	localparam logic [3:0] HOLD_SHIFT_RST = 4'h8;
	// Path modes, one-hot
	typedef enum logic [2:0] {
		MODE_FREE = 3'b001,
		MODE_LOCK = 3'b010,
		MODE_HOLD = 3'b100
	} drs_mode_e;
	// Per-path software control
	typedef struct packed {
		logic              force_en;
		logic [3:0]        force_sel;
	} drs_path_cfg_s;
	// Per-path status
	typedef struct packed {
		drs_mode_e         mode;
		logic              have;
		logic [3:0]        sel;
	} drs_path_stat_s;
endpackage : drs_pkg

/* File: hw/drs_prio_pick.sv */
// Purpose: Pick the eligible reference with the best priority value
// Assumes: Priorities unique per path; lowest index wins any tie
// Notes:   Purely combinational, result registered by the caller
`timescale 1ns/10ps
module drs_prio_pick (
	// Candidates
	input  wire logic [drs_pkg::N_REF-1:0]                    avail,
	input  wire logic [drs_pkg::N_REF-1:0][drs_pkg::PRIO_W-1:0] prio,
	// Result
	output logic                                              found,
	output logic [3:0]                                        idx
);
	logic [drs_pkg::N_REF-1:0] elig;
	logic [drs_pkg::PRIO_W-1:0] best;

	// Zero priority removes an input from the table
	genvar gi;
	generate
		for (gi = 0; gi < drs_pkg::N_REF; gi++) begin : g_elig
			assign elig[gi] = avail[gi] && (prio[gi] != 4'h0);
		end
	endgenerate

	// Lowest nonzero value is the most preferred
	always_comb begin
		found = 1'b0;
		idx   = 4'h0;
		best  = 4'hF;
		for (int i = 0; i < drs_pkg::N_REF; i++) begin
			if (elig[i] && (!found || prio[i] < best)) begin
				found = 1'b1;
				best  = prio[i];
				idx   = 4'(i);
			end
		end
	end
endmodule : drs_prio_pick

/* File: hw/drs_ref_select.sv */
// Purpose: Reference selection and mode control for main and aux paths
// Assumes: Monitor flags and edges are on clk_sys; config ports are static
// Notes:   Loop arithmetic lives elsewhere; this block steers it
`timescale 1ns/10ps
module drs_ref_select (
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       nrst,
	// Monitor results and reference edges
	input  wire logic [17:0]                mon_valid,
	input  wire logic [17:0]                ref_edge,
	// Port enables and priority tables
	input  wire logic [17:0]                port_en,
	input  wire logic [13:0][3:0]           main_prio,
	input  wire logic [13:0][3:0]           aux_prio,
	// Path control
	input  wire drs_pkg::drs_path_cfg_s     main_cfg,
	input  wire drs_pkg::drs_path_cfg_s     aux_cfg,
	input  wire logic                       main_sw_hold,
	input  wire logic                       main_sw_mode_en,
	input  wire drs_pkg::drs_mode_e         main_sw_mode,
	input  wire logic                       main_nonrev,
	input  wire logic                       aux_follow,
	// Main loop extras
	input  wire logic                       pbo_en,
	input  wire logic signed [15:0]         loop_phase_err,
	input  wire logic signed [15:0]         io_phase_ofs,
	input  wire logic signed [15:0]         loop_freq,
	input  wire logic                       man_hold_en,
	input  wire logic signed [15:0]         man_hold_freq,
	input  wire logic [3:0]                 hold_shift,
	input  wire logic                       noise_rej_en,
	input  wire logic                       fsync_en,
	input  wire logic [3:0]                 main_bw,
	input  wire logic [1:0]                 aux_bw,
	input  wire logic [13:0]                divn_n,
	// Output routing
	input  wire logic [10:0]                out_use_aux,
	input  wire logic [3:0][3:0]            pin_src,
	// Phase measurement selects
	input  wire logic [4:0]                 meas_a,
	input  wire logic [4:0]                 meas_b,
	// Status
	output drs_pkg::drs_path_stat_s         main_stat_reg,
	output drs_pkg::drs_path_stat_s         aux_stat_reg,
	output logic [17:0]                     port_en_reg,
	// Loop steering
	output logic signed [15:0]              phase_adj_reg,
	output logic                            pbo_load_reg,
	output logic signed [15:0]              hold_freq_reg,
	output logic [3:0]                      main_bw_reg,
	output logic [1:0]                      aux_bw_reg,
	output logic [16:0]                     main_dds_khz_reg,
	output logic [16:0]                     aux_lock_khz_reg,
	output logic                            aux_src_main_reg,
	output logic [13:0]                     divn_n_reg,
	output logic                            divn_ok_reg,
	output logic                            noise_rej_reg,
	output logic                            fsync_reg,
	// Output routing
	output logic [10:0]                     out_use_aux_reg,
	output logic [3:0][3:0]                 pin_src_reg,
	output logic [3:0]                      pin_en_reg,
	// Phase measurement
	output logic [15:0]                     meas_cycles_reg,
	output logic                            meas_done_reg
);
	logic [13:0]              avail;
	logic                     main_found;
	logic [3:0]               main_pick;
	logic                     aux_found;
	logic [3:0]               aux_pick;
	logic                     main_have_next;
	logic [3:0]               main_sel_next;
	logic                     aux_have_next;
	logic [3:0]               aux_sel_next;
	drs_pkg::drs_mode_e       main_mode_next;
	drs_pkg::drs_mode_e       aux_mode_next;
	logic signed [15:0]       avg_reg;
	logic signed [15:0]       pbo_ofs_reg;
	logic                     switch_reg;
	logic                     meas_run_reg;
	logic [15:0]              meas_cnt_reg;

	// Every check below lives on clk_sys and sleeps through reset
	default clocking drs_cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////
	// Availability and priority picking

	// Port enables start cleared
	// ports disabled after reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			port_en_reg <= drs_pkg::PORT_EN_RST;
		end else begin
			port_en_reg <= port_en;
		end
	end

	// Only the first 14 inputs feed the tables; monitors act without delay
	// fourteen usable references
	assign avail = port_en_reg[13:0] & mon_valid[13:0];

	drs_prio_pick u_main_pick (
		.avail (avail),
		.prio  (main_prio),
		.found (main_found),
		.idx   (main_pick)
	);

	drs_prio_pick u_aux_pick (
		.avail (avail),
		.prio  (aux_prio),
		.found (aux_found),
		.idx   (aux_pick)
	);

	////////////////////////////////////////////////////////////////////////
	// Main path selection and mode

	// Forced pick wins; non-revertive keeps a still valid choice
	// forced reference
	always_comb begin
		main_sel_next  = main_pick;
		main_have_next = main_found;
		if (main_cfg.force_en) begin
			main_sel_next  = main_cfg.force_sel;
			main_have_next = (main_cfg.force_sel < 4'hE) &&
				avail[main_cfg.force_sel];
		end else if (main_nonrev && main_stat_reg.have &&
				avail[main_stat_reg.sel] &&
				main_prio[main_stat_reg.sel] != 4'h0) begin
			main_sel_next  = main_stat_reg.sel;
			main_have_next = 1'b1;
		end
	end

	// Software mode beats forced holdover, which beats automatic moves
	// holdover without reference
	always_comb begin
		main_mode_next = main_stat_reg.mode;
		if (main_sw_mode_en) begin
			main_mode_next = main_sw_mode;
		end else if (main_sw_hold) begin
			main_mode_next = drs_pkg::MODE_HOLD;
		end else begin
			case (main_stat_reg.mode)
				drs_pkg::MODE_FREE: begin
					if (main_have_next) main_mode_next = drs_pkg::MODE_LOCK;
				end
				drs_pkg::MODE_LOCK: begin
					if (!main_have_next) main_mode_next = drs_pkg::MODE_HOLD;
				end
				drs_pkg::MODE_HOLD: begin
					if (main_have_next) main_mode_next = drs_pkg::MODE_LOCK;
				end
				default: main_mode_next = drs_pkg::MODE_FREE;
			endcase
		end
	end

	// Status register, reevaluated every cycle
	// readable mode and input
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			main_stat_reg <= '{mode: drs_pkg::MODE_FREE, have: 1'b0,
				sel: 4'h0};
			switch_reg    <= 1'b0;
		end else begin
			main_stat_reg <= '{mode: main_mode_next, have: main_have_next,
				sel: main_sel_next};
			switch_reg    <= main_have_next && main_stat_reg.have &&
				(main_sel_next != main_stat_reg.sel);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Aux path selection and mode

	// Simple machine, steered only through reference choice, or main mode when following
	// aux not settable
	always_comb begin
		aux_sel_next  = aux_pick;
		aux_have_next = aux_found;
		if (aux_cfg.force_en) begin
			aux_sel_next  = aux_cfg.force_sel;
			aux_have_next = (aux_cfg.force_sel < 4'hE) &&
				avail[aux_cfg.force_sel];
		end
		if (aux_follow) begin
			aux_have_next = main_stat_reg.mode != drs_pkg::MODE_FREE;
		end
		case (aux_stat_reg.mode)
			drs_pkg::MODE_FREE: aux_mode_next = aux_have_next ?
				drs_pkg::MODE_LOCK : drs_pkg::MODE_FREE;
			drs_pkg::MODE_LOCK: aux_mode_next = aux_have_next ?
				drs_pkg::MODE_LOCK : drs_pkg::MODE_HOLD;
			drs_pkg::MODE_HOLD: aux_mode_next = aux_have_next ?
				drs_pkg::MODE_LOCK : drs_pkg::MODE_HOLD;
			default: aux_mode_next = drs_pkg::MODE_FREE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			aux_stat_reg <= '{mode: drs_pkg::MODE_FREE, have: 1'b0,
				sel: 4'h0};
		end else begin
			aux_stat_reg <= '{mode: aux_mode_next, have: aux_have_next,
				sel: aux_sel_next};
		end
	end

	// Follow mode locks to the main 8 kHz, else to the own reference
	// aux from main
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			aux_src_main_reg <= 1'b0;
			aux_lock_khz_reg <= 17'h00000;
		end else begin
			aux_src_main_reg <= aux_follow;
			aux_lock_khz_reg <= aux_follow ? drs_pkg::FOLLOW_KHZ : 17'h00000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Holdover frequency and phase build-out

	// Average only while locked to a good input, so failure freezes it
	// long-term average
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			avg_reg       <= 16'sh0000;
			hold_freq_reg <= 16'sh0000;
		end else begin
			if (main_stat_reg.mode == drs_pkg::MODE_LOCK &&
					main_stat_reg.have && main_have_next) begin
				avg_reg <= 16'(avg_reg + ((loop_freq - avg_reg) >>> hold_shift));
			end
			hold_freq_reg <= man_hold_en ? man_hold_freq : avg_reg;
		end
	end

	// Absorb the new reference's phase step, hiding it from the output
	// build-out on switch
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pbo_ofs_reg   <= 16'sh0000;
			pbo_load_reg  <= 1'b0;
			phase_adj_reg <= 16'sh0000;
		end else begin
			pbo_load_reg <= switch_reg && pbo_en;
			if (switch_reg && pbo_en) begin
				pbo_ofs_reg <= 16'(pbo_ofs_reg - loop_phase_err);
			end
			phase_adj_reg <= 16'(pbo_ofs_reg + io_phase_ofs);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Loop settings

	// Out of range bandwidth codes are ignored, keeping the last good setting
	// bandwidth steps
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			main_bw_reg      <= drs_pkg::BW_MAIN_RST;
			aux_bw_reg       <= drs_pkg::BW_AUX_18HZ;
			main_dds_khz_reg <= drs_pkg::MAIN_DDS_KHZ;
			divn_n_reg       <= drs_pkg::DIVN_N_MIN;
			divn_ok_reg      <= 1'b0;
			noise_rej_reg    <= 1'b0;
			fsync_reg        <= 1'b0;
		end else begin
			if (main_bw < drs_pkg::BW_MAIN_STEPS) main_bw_reg <= main_bw;
			if (aux_bw <= drs_pkg::BW_AUX_70HZ) aux_bw_reg <= aux_bw;
			main_dds_khz_reg <= drs_pkg::MAIN_DDS_KHZ;
			divn_n_reg       <= divn_n;
			divn_ok_reg      <= (divn_n >= drs_pkg::DIVN_N_MIN) &&
				(divn_n <= drs_pkg::DIVN_N_MAX);
			noise_rej_reg    <= noise_rej_en;
			fsync_reg        <= fsync_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output routing

	// Sources past the last output leave the pin undriven by the mux
	// output counts
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			out_use_aux_reg <= 11'h000;
			pin_src_reg     <= '0;
			pin_en_reg      <= 4'h0;
		end else begin
			out_use_aux_reg <= out_use_aux;
			pin_src_reg     <= pin_src;
			for (int p = 0; p < drs_pkg::N_PIN; p++) begin
				pin_en_reg[p] <= pin_src[p] < 4'hB;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Aux phase measurement between two inputs

	// Counts cycles from an edge on A to the next edge on B
	// phase difference
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meas_run_reg    <= 1'b0;
			meas_cnt_reg    <= 16'h0000;
			meas_cycles_reg <= 16'h0000;
			meas_done_reg   <= 1'b0;
		end else begin
			meas_done_reg <= 1'b0;
			if (meas_run_reg && meas_b < 5'h12 && ref_edge[meas_b]) begin
				meas_run_reg    <= 1'b0;
				meas_cycles_reg <= meas_cnt_reg;
				meas_done_reg   <= 1'b1;
			end else if (meas_run_reg) begin
				meas_cnt_reg <= 16'(meas_cnt_reg + 16'h0001);
			end else if (meas_a < 5'h12 && ref_edge[meas_a]) begin
				meas_run_reg <= 1'b1;
				meas_cnt_reg <= 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	AST_NO_AVAIL_DROP: assert property (
		(avail == 14'h0000 && !aux_follow) |=> (!main_stat_reg.have &&
		!aux_stat_reg.have)) else $error("selection kept without input");

	AST_SW_HOLD: assert property (
		(main_sw_hold && !main_sw_mode_en) [*2] |->
		main_stat_reg.mode == drs_pkg::MODE_HOLD)
		else $error("forced holdover not honoured");

	AST_FORCE_SEL: assert property (
		(main_cfg.force_en && main_cfg.force_sel < 4'hE &&
		avail[main_cfg.force_sel]) |=> (main_stat_reg.have &&
		main_stat_reg.sel == $past(main_cfg.force_sel)))
		else $error("forced reference not taken");

	AST_SEL_RANGE: assert property (
		main_stat_reg.have |-> main_stat_reg.sel < 4'hE)
		else $error("selection beyond usable references");

	AST_LOSS_HOLD: assert property (
		(main_stat_reg.mode == drs_pkg::MODE_LOCK && !main_have_next &&
		!main_sw_mode_en) |=> main_stat_reg.mode == drs_pkg::MODE_HOLD)
		else $error("no holdover after loss");

	AST_HOLD_FREEZE: assert property (
		main_stat_reg.mode == drs_pkg::MODE_HOLD |=> $stable(avg_reg))
		else $error("holdover average moved");

	AST_FOLLOW_8K: assert property (
		aux_follow |=> (aux_src_main_reg &&
		aux_lock_khz_reg == drs_pkg::FOLLOW_KHZ))
		else $error("aux not locked to 8 kHz");

	AST_PBO_LOAD: assert property (
		(main_have_next && main_stat_reg.have && pbo_en &&
		main_sel_next != main_stat_reg.sel) |-> ##1 pbo_en |-> ##1 pbo_load_reg)
		else $error("build-out missed on switch");

	AST_PIN_EN: assert property (
		pin_src[0] > 4'hA |=> !pin_en_reg[0])
		else $error("pin enabled for missing source");

	AST_BW_CLAMP: assert property (
		main_bw >= drs_pkg::BW_MAIN_STEPS |=> $stable(main_bw_reg))
		else $error("bandwidth took invalid code");
endmodule : drs_ref_select

/* File: dv/drs_src_model.sv */
// Purpose: Reference sources and monitor view for reference select
// Assumes: Bench hands in failure requests already soaked by host timers
// Notes:   Input i pulses at phase i of a 32-cycle lap
`timescale 1ns/10ps
module drs_src_model (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Soaked failure requests
	input  wire logic [17:0] fail_req,
	// Monitor view
	output logic      [17:0] mon_valid,
	output logic      [17:0] ref_edge
);
	logic [4:0] phase_reg;
	////////////////////////////////////////////////////////////////////////
	// Lap counter, fixed spacing between input edges
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			phase_reg <= 5'h00;
		else
			phase_reg <= phase_reg + 5'h01;
	end
	// One-cycle edge pulse per input per lap
	always_comb begin
		for (int i = 0; i < 18; i++)
			ref_edge[i] = (phase_reg == i[4:0]);
	end
	// host soaked alarms
	// Raw alarms never reach here unfiltered; one cycle of soak
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			mon_valid <= 18'h3FFFF;
		else
			mon_valid <= ~fail_req;
	end
endmodule : drs_src_model

/* File: dv/dual_path_ref_select_dpll_test.sv */
// Purpose: Self-checking bench for dual path reference select
// Assumes: Inputs change on falling edges, outputs read there
// Notes:   Hold filter input stays constant, manual holdover value checked
`timescale 1ns/10ps
module dual_path_ref_select_dpll_test;
	logic clk_sys = 1'b0, nrst = 1'b0;
	logic [17:0] mon_valid, ref_edge, fail_req, port_en, port_en_reg;
	logic [13:0][3:0] main_prio, aux_prio;
	drs_pkg::drs_path_cfg_s main_cfg, aux_cfg;
	drs_pkg::drs_path_stat_s main_stat_reg, aux_stat_reg;
	drs_pkg::drs_mode_e main_sw_mode;
	logic main_sw_hold, main_sw_mode_en, main_nonrev, aux_follow, pbo_en;
	logic man_hold_en, noise_rej_en, fsync_en, pbo_load_reg, divn_ok_reg;
	logic signed [15:0] loop_phase_err, io_phase_ofs, loop_freq;
	logic signed [15:0] man_hold_freq, phase_adj_reg, hold_freq_reg;
	logic [3:0] hold_shift, main_bw, main_bw_reg, pin_en_reg;
	logic [1:0] aux_bw, aux_bw_reg;
	logic [13:0] divn_n, divn_n_reg;
	logic [10:0] out_use_aux, out_use_aux_reg;
	logic [3:0][3:0] pin_src, pin_src_reg;
	logic [4:0] meas_a, meas_b;
	logic [16:0] main_dds_khz_reg, aux_lock_khz_reg;
	logic aux_src_main_reg, noise_rej_reg, fsync_reg, meas_done_reg;
	logic [15:0] meas_cycles_reg;
	int mismatches = 0;
	int total_checks = 0;
	////////////////////////////////////////////////////////////////////////
	// Clock, device and source model
	always #10 clk_sys = ~clk_sys;
	drs_ref_select drs_ref_select_inst (
		.clk_sys(clk_sys), .nrst(nrst), .mon_valid(mon_valid),
		.ref_edge(ref_edge), .port_en(port_en), .main_prio(main_prio),
		.aux_prio(aux_prio), .main_cfg(main_cfg), .aux_cfg(aux_cfg),
		.main_sw_hold(main_sw_hold), .main_sw_mode_en(main_sw_mode_en),
		.main_sw_mode(main_sw_mode), .main_nonrev(main_nonrev),
		.aux_follow(aux_follow), .pbo_en(pbo_en),
		.loop_phase_err(loop_phase_err), .io_phase_ofs(io_phase_ofs),
		.loop_freq(loop_freq), .man_hold_en(man_hold_en),
		.man_hold_freq(man_hold_freq), .hold_shift(hold_shift),
		.noise_rej_en(noise_rej_en), .fsync_en(fsync_en),
		.main_bw(main_bw), .aux_bw(aux_bw), .divn_n(divn_n),
		.out_use_aux(out_use_aux), .pin_src(pin_src), .meas_a(meas_a),
		.meas_b(meas_b), .main_stat_reg(main_stat_reg),
		.aux_stat_reg(aux_stat_reg), .port_en_reg(port_en_reg),
		.phase_adj_reg(phase_adj_reg), .pbo_load_reg(pbo_load_reg),
		.hold_freq_reg(hold_freq_reg), .main_bw_reg(main_bw_reg),
		.aux_bw_reg(aux_bw_reg), .main_dds_khz_reg(main_dds_khz_reg),
		.aux_lock_khz_reg(aux_lock_khz_reg),
		.aux_src_main_reg(aux_src_main_reg), .divn_n_reg(divn_n_reg),
		.divn_ok_reg(divn_ok_reg), .noise_rej_reg(noise_rej_reg),
		.fsync_reg(fsync_reg), .out_use_aux_reg(out_use_aux_reg),
		.pin_src_reg(pin_src_reg), .pin_en_reg(pin_en_reg),
		.meas_cycles_reg(meas_cycles_reg), .meas_done_reg(meas_done_reg));
	drs_src_model drs_src_model_inst (.clk_sys(clk_sys), .nrst(nrst),
		.fail_req(fail_req), .mon_valid(mon_valid), .ref_edge(ref_edge));
	////////////////////////////////////////////////////////////////////////
	// Compare and count, print only on mismatch
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	// Status word as mode, have, sel
	function automatic logic [7:0] st(input drs_pkg::drs_mode_e m,
		input logic h, input logic [3:0] s);
		return {m, h, s};
	endfunction : st
	// Select chain is two registers deep, three falls covers it
	task automatic step;
		repeat (3) @(negedge clk_sys);
	endtask : step
	// Bounded wait for a one-cycle pulse
	task automatic wait_hi(input bit use_meas);
		int n;
		n = 0;
		while ((use_meas ? meas_done_reg : pbo_load_reg) !== 1'b1 && n < 80) begin
			@(negedge clk_sys);
			n++;
		end
		if ((use_meas ? meas_done_reg : pbo_load_reg) !== 1'b1) begin
			mismatches++;
			end_of_test();
		end
	endtask : wait_hi
	////////////////////////////////////////////////////////////////////////
	// Reset values, then a port that cannot be a reference
	task automatic t_reset;
		check("main_stat", main_stat_reg, st(drs_pkg::MODE_FREE, 0, 0));
		check("port_en", port_en_reg, 18'h00000);
		check("dds", main_dds_khz_reg, drs_pkg::MAIN_DDS_KHZ);
		nrst = 1'b1;
		port_en = 18'h08000;
		step();
		check("no_ref", main_stat_reg.have, 1'b0);
	endtask : t_reset
	// Two priority tables give different picks
	task automatic t_select;
		port_en = 18'h080A8;
		step();
		check("main_sel", main_stat_reg, st(drs_pkg::MODE_LOCK, 1, 3));
		check("aux_sel", aux_stat_reg, st(drs_pkg::MODE_LOCK, 1, 5));
		check("ofs", phase_adj_reg, 16'sh0004);
	endtask : t_select
	// Failover with build-out, then only a zero-priority input left, then restore
	task automatic t_fail;
		fail_req = 18'h00008;
		wait_hi(1'b0);
		step();
		check("next", main_stat_reg, st(drs_pkg::MODE_LOCK, 1, 5));
		check("pbo", phase_adj_reg, 16'shFFF4);
		fail_req = 18'h00028;
		step();
		check("hold", main_stat_reg.mode, drs_pkg::MODE_HOLD);
		check("aux_hold", aux_stat_reg.mode, drs_pkg::MODE_HOLD);
		check("excl", main_stat_reg.have, 1'b0);
		fail_req = 18'h00000;
		step();
		check("back", main_stat_reg, st(drs_pkg::MODE_LOCK, 1, 3));
	endtask : t_fail
	// Forced picks, including a zero-priority and an illegal index
	task automatic t_force;
		main_cfg = '{1'b1, 4'h7};
		aux_cfg = '{1'b1, 4'h3};
		step();
		check("force", main_stat_reg.sel, 4'h7);
		check("aux_force", aux_stat_reg.sel, 4'h3);
		main_cfg = '{1'b1, 4'hE};
		step();
		check("bad_force", main_stat_reg.have, 1'b0);
		main_cfg = '{1'b0, 4'h0};
		aux_cfg = '{1'b0, 4'h0};
		main_sw_hold = 1'b1;
		step();
		check("sw_hold", main_stat_reg.mode, drs_pkg::MODE_HOLD);
		main_sw_mode_en = 1'b1;
		step();
		check("sw_mode", main_stat_reg.mode, drs_pkg::MODE_FREE);
		main_sw_mode_en = 1'b0;
		main_sw_hold = 1'b0;
		step();
		check("release", main_stat_reg.mode, drs_pkg::MODE_LOCK);
		main_nonrev = 1'b1;
		fail_req = 18'h00008;
		step();
		fail_req = 18'h00000;
		step();
		check("nonrev", main_stat_reg.sel, 4'h5);
		main_nonrev = 1'b0;
		step();
		check("revert", main_stat_reg.sel, 4'h3);
	endtask : t_force
	// Bandwidth limits, follow, routing, divider, enables
	task automatic t_misc;
		main_bw = 4'h9;
		aux_bw = 2'h2;
		aux_follow = 1'b1;
		man_hold_en = 1'b1;
		man_hold_freq = 16'sh1234;
		out_use_aux = 11'h401;
		pin_src = {4'h3, 4'hA, 4'h0, 4'hB};
		divn_n = 14'h30D3;
		step();
		main_bw = 4'hA;
		aux_bw = 2'h3;
		step();
		check("main_bw", main_bw_reg, 4'h9);
		check("aux_bw", aux_bw_reg, drs_pkg::BW_AUX_70HZ);
		check("follow", aux_lock_khz_reg, drs_pkg::FOLLOW_KHZ);
		check("src_main", aux_src_main_reg, 1'b1);
		check("use_aux", out_use_aux_reg, 11'h401);
		check("pin_en", pin_en_reg, 4'hE);
		check("pin_src", pin_src_reg, 16'h3A0B);
		check("divn_ok", divn_ok_reg, 1'b1);
		check("divn_n", divn_n_reg, 14'h30D3);
		check("man_hold", hold_freq_reg, 16'sh1234);
		divn_n = 14'h30D4;
		step();
		check("divn_bad", divn_ok_reg, 1'b0);
		check("passthru", {noise_rej_reg, fsync_reg}, 2'h3);
	endtask : t_misc
	// Phase gap between inputs 2 and 7 is five cycles
	task automatic t_meas;
		meas_a = 5'h02;
		meas_b = 5'h07;
		wait_hi(1'b1);
		check("meas", meas_cycles_reg, 16'h0005);
	endtask : t_meas
	////////////////////////////////////////////////////////////////////////
	// Time-zero values, reset, scenarios
	initial begin
		fail_req = 18'h00000;
		port_en = 18'h00000;
		main_prio = '0;
		aux_prio = '0;
		main_prio[3] = 4'h1;
		main_prio[5] = 4'h2;
		aux_prio[5] = 4'h1;
		aux_prio[3] = 4'h2;
		main_cfg = '0;
		aux_cfg = '0;
		{main_sw_hold, main_sw_mode_en, main_nonrev, aux_follow} = 4'h0;
		main_sw_mode = drs_pkg::MODE_FREE;
		{pbo_en, man_hold_en, noise_rej_en, fsync_en} = 4'hB;
		loop_phase_err = 16'sh0010;
		io_phase_ofs = 16'sh0004;
		loop_freq = 16'sh0000;
		man_hold_freq = 16'sh0000;
		hold_shift = drs_pkg::HOLD_SHIFT_RST;
		{main_bw, aux_bw, divn_n} = 20'h00001;
		{out_use_aux, pin_src} = '0;
		{meas_a, meas_b} = 10'h3FF;
		repeat (4) @(negedge clk_sys);
		t_reset();
		t_select();
		t_fail();
		t_force();
		t_misc();
		t_meas();
		end_of_test();
	end
endmodule : dual_path_ref_select_dpll_test
